// ---- common/ftar_defines.vh ----
`ifndef FTAR_DEFINES_VH
`define FTAR_DEFINES_VH

// Register indices on the CPU register port
`define FTAR_IDX_START      4'h0
`define FTAR_IDX_TRAN       4'h1
`define FTAR_IDX_PROG       4'h2
`define FTAR_IDX_PERASE     4'h3
`define FTAR_IDX_MERASE     4'h4
`define FTAR_IDX_END        4'h5
`define FTAR_IDX_MEND       4'h6
`define FTAR_IDX_RCV        4'h7
`define FTAR_IDX_DIV        4'h8
`define FTAR_IDX_FUNC       4'h9
`define FTAR_IDX_PROT       4'ha
`define FTAR_IDX_CAS        4'hb
`define FTAR_IDX_FUNC_ALIAS 4'hc
`define FTAR_IDX_PROT_ALIAS 4'hd
`define FTAR_IDX_CAS_ALIAS  4'he

// Reset values, applied only when the array is idle at reset
`define FTAR_RST_START  8'h18
`define FTAR_RST_TRAN   8'h30
`define FTAR_RST_PROG   8'h16
`define FTAR_RST_PERASE 8'h04
`define FTAR_RST_MERASE 8'hea
`define FTAR_RST_END    8'h18
`define FTAR_RST_MEND   8'h3c
`define FTAR_RST_RCV    8'h04
`define FTAR_RST_DIV    5'h04

// Phase length multipliers as shift amounts
`define FTAR_SH_ONE   4'h0
`define FTAR_SH_PROG  4'h3
`define FTAR_SH_ERASE 4'hc
`define FTAR_SH_MEND  4'h3

// Code area start fields
`define FTAR_CAS_LO_W   11
`define FTAR_BOOT_LSB   0
`define FTAR_BOOT_W     4

// Cycles after reset release before straps are trusted
`define FTAR_INIT_CYC 2'h3

// Operation kinds
`define FTAR_OP_PROG   2'h0
`define FTAR_OP_PERASE 2'h1
`define FTAR_OP_MERASE 2'h2

`endif

// ---- hw/ftar_delay.v ----
// Counts a loaded number of prescaler ticks, then pulses done
module ftar_delay #(
   parameter W = 21
) (
   input wire i_clk,          // System clock
   input wire i_nrst,         // Async reset, active low
   input wire i_load,         // Start a new delay
   input wire [W-1:0] i_len,  // Length in ticks, at least one
   input wire i_tick,         // Prescaler output enable
   output reg o_done          // One-cycle pulse at the end
);

   reg [W-1:0] cnt_q;
   reg run_q;

   // ************************************
   // Down counter
   // ************************************
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         cnt_q <= {W{1'b0}};
         run_q <= 1'b0;
         o_done <= 1'b0;
      end
      else
      begin
         o_done <= 1'b0;
         if (i_load)
         begin
            cnt_q <= i_len - {{(W-1){1'b0}}, 1'b1};
            run_q <= 1'b1;
         end
         else if (run_q && i_tick)
         begin
            if (cnt_q == {W{1'b0}})
            begin
               run_q <= 1'b0;
               o_done <= 1'b1;
            end
            else
               cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // ftar_delay

// ---- hw/ftar_top.v ----
`include "ftar_defines.vh"

module ftar_top #(
   parameter DW = 21
) (
   input wire i_clk,                // System clock, 40 MHz
   input wire i_nrst,               // Async reset, active low
   input wire [3:0] i_reg_idx,      // Register index
   input wire i_reg_wr,             // Register write strobe
   input wire i_reg_rd,             // Register read strobe
   input wire [7:0] i_reg_wdata,    // Write data
   output reg [15:0] o_reg_rdata,   // Read data, one cycle late
   input wire i_op_start,           // Start program or erase
   input wire [1:0] i_op_kind,      // Operation kind
   input wire i_array_busy,         // Array busy, from outside
   input wire [15:0] i_func_word,   // Function word of info block 0
   input wire [15:0] i_prot_word,   // Protection word of info block 1
   input wire [15:0] i_cas_addr,    // Code area address straps
   output reg o_flash_busy,         // Busy flag
   output reg o_prog_pulse,         // Programming pulse to array
   output reg o_erase_pulse,        // Erase pulse to array
   output reg o_op_done,            // Operation finished pulse
   output reg o_init_done,          // Straps captured
   output reg [15:0] o_prot_word,   // Active protection settings
   output reg [15:0] o_code_area_start // Branch displacement
);

   localparam S_IDLE = 3'h0;
   localparam S_START = 3'h1;
   localparam S_TRAN = 3'h2;
   localparam S_PULSE = 3'h3;
   localparam S_END = 3'h4;
   localparam S_RCV = 3'h5;

   reg [7:0] start_delay_reload_q;
   reg [7:0] transition_time_reload_q;
   reg [7:0] program_pulse_reload_q;
   reg [7:0] page_erase_pulse_reload_q;
   reg [7:0] module_erase_pulse_reload_q;
   reg [7:0] end_delay_reload_q;
   reg [7:0] module_erase_end_reload_q;
   reg [7:0] recovery_delay_reload_q;
   reg [4:0] prescale_divisor_q;
   reg [15:0] function_word_copy_q;
   reg [15:0] protection_word_copy_q;
   reg [15:0] code_area_start_q;

   reg busy_s1_q;
   reg busy_s2_q;
   reg [15:0] func_s1_q;
   reg [15:0] func_s2_q;
   reg [15:0] prot_s1_q;
   reg [15:0] prot_s2_q;
   reg [15:0] cas_s1_q;
   reg [15:0] cas_s2_q;
   reg [1:0] init_cnt_q;
   reg init_done_q;

   reg [4:0] div_cnt_q;
   reg tick_q;
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [1:0] kind_q;
   reg load_q;
   reg [7:0] len_cnt;
   reg [3:0] len_sh;
   reg [DW-1:0] len;
   wire dly_done;
   wire seq_busy;
   wire wr_ok;

   assign seq_busy = (state_q != S_IDLE);
   assign wr_ok = i_reg_wr && !seq_busy && init_done_q;

   // ************************************
   // Synchronisers for array-side inputs
   // ************************************
   // Two flops ahead of any logic
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         busy_s1_q <= 1'b0;
         busy_s2_q <= 1'b0;
         func_s1_q <= 16'h0000;
         func_s2_q <= 16'h0000;
         prot_s1_q <= 16'h0000;
         prot_s2_q <= 16'h0000;
         cas_s1_q <= 16'h0000;
         cas_s2_q <= 16'h0000;
      end
      else
      begin
         busy_s1_q <= i_array_busy;
         busy_s2_q <= busy_s1_q;
         func_s1_q <= i_func_word;
         func_s2_q <= func_s1_q;
         prot_s1_q <= i_prot_word;
         prot_s2_q <= prot_s1_q;
         cas_s1_q <= i_cas_addr;
         cas_s2_q <= cas_s1_q;
      end
   end

   // ************************************
   // Reset capture
   // ************************************
   // Waits for synchronised straps after release
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         init_cnt_q <= 2'h0;
         init_done_q <= 1'b0;
      end
      else if (!init_done_q)
      begin
         if (init_cnt_q == `FTAR_INIT_CYC)
            init_done_q <= 1'b1;
         else
            init_cnt_q <= init_cnt_q + 2'h1;
      end
   end

   // Auto-read words sampled once per reset, never written by CPU
   always @(posedge i_clk)
   begin
      if (!init_done_q && init_cnt_q == `FTAR_INIT_CYC)
      begin
         function_word_copy_q <= func_s2_q;
         protection_word_copy_q <= prot_s2_q;
         code_area_start_q <= {cas_s2_q[15],
            prot_s2_q[`FTAR_BOOT_LSB +: `FTAR_BOOT_W],
            cas_s2_q[`FTAR_CAS_LO_W-1:0]};
      end
   end

   // ************************************
   // Timing reload registers
   // ************************************
   // Held through reset; defaults only if array was idle
   always @(posedge i_clk)
   begin
      if (!init_done_q && init_cnt_q == `FTAR_INIT_CYC)
      begin
         if (!busy_s2_q)
         begin
            start_delay_reload_q <= `FTAR_RST_START;
            transition_time_reload_q <= `FTAR_RST_TRAN;
            program_pulse_reload_q <= `FTAR_RST_PROG;
            page_erase_pulse_reload_q <= `FTAR_RST_PERASE;
            module_erase_pulse_reload_q <= `FTAR_RST_MERASE;
            end_delay_reload_q <= `FTAR_RST_END;
            module_erase_end_reload_q <= `FTAR_RST_MEND;
            recovery_delay_reload_q <= `FTAR_RST_RCV;
            prescale_divisor_q <= `FTAR_RST_DIV;
         end
      end
      else if (wr_ok)
      begin
         case (i_reg_idx)
            `FTAR_IDX_START: start_delay_reload_q <= i_reg_wdata;
            `FTAR_IDX_TRAN: transition_time_reload_q <= i_reg_wdata;
            `FTAR_IDX_PROG: program_pulse_reload_q <= i_reg_wdata;
            `FTAR_IDX_PERASE: page_erase_pulse_reload_q <= i_reg_wdata;
            `FTAR_IDX_MERASE: module_erase_pulse_reload_q <= i_reg_wdata;
            `FTAR_IDX_END: end_delay_reload_q <= i_reg_wdata;
            `FTAR_IDX_MEND: module_erase_end_reload_q <= i_reg_wdata;
            `FTAR_IDX_RCV: recovery_delay_reload_q <= i_reg_wdata;
            `FTAR_IDX_DIV: prescale_divisor_q <= i_reg_wdata[4:0];
            default: ;
         endcase
      end
   end

   // ************************************
   // Register read port
   // ************************************
   // Registered read data, unmapped reads give zero
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         o_reg_rdata <= 16'h0000;
      else if (i_reg_rd)
      begin
         case (i_reg_idx)
            `FTAR_IDX_START: o_reg_rdata <= {8'h00, start_delay_reload_q};
            `FTAR_IDX_TRAN: o_reg_rdata <= {8'h00, transition_time_reload_q};
            `FTAR_IDX_PROG: o_reg_rdata <= {8'h00, program_pulse_reload_q};
            `FTAR_IDX_PERASE: o_reg_rdata <= {8'h00, page_erase_pulse_reload_q};
            `FTAR_IDX_MERASE: o_reg_rdata <= {8'h00, module_erase_pulse_reload_q};
            `FTAR_IDX_END: o_reg_rdata <= {8'h00, end_delay_reload_q};
            `FTAR_IDX_MEND: o_reg_rdata <= {8'h00, module_erase_end_reload_q};
            `FTAR_IDX_RCV: o_reg_rdata <= {8'h00, recovery_delay_reload_q};
            `FTAR_IDX_DIV: o_reg_rdata <= {11'h000, prescale_divisor_q};
            `FTAR_IDX_FUNC: o_reg_rdata <= function_word_copy_q;
            `FTAR_IDX_PROT: o_reg_rdata <= protection_word_copy_q;
            `FTAR_IDX_CAS: o_reg_rdata <= code_area_start_q;
            `FTAR_IDX_FUNC_ALIAS: o_reg_rdata <= function_word_copy_q;
            `FTAR_IDX_PROT_ALIAS: o_reg_rdata <= protection_word_copy_q;
            `FTAR_IDX_CAS_ALIAS: o_reg_rdata <= code_area_start_q;
            default: o_reg_rdata <= 16'h0000;
         endcase
      end
   end

   // ************************************
   // Prescaler
   // ************************************
   // One tick every divisor plus one clocks
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         div_cnt_q <= 5'h00;
         tick_q <= 1'b0;
      end
      else if (init_done_q && div_cnt_q >= prescale_divisor_q)
      begin
         div_cnt_q <= 5'h00;
         tick_q <= 1'b1;
      end
      else
      begin
         div_cnt_q <= init_done_q ? div_cnt_q + 5'h01 : 5'h00; // Held clear until init
         tick_q <= 1'b0;
      end
   end

   // ************************************
   // Phase length selection
   // ************************************
   // Count and multiplier of the phase just entered
   always @*
   begin
      len_cnt = start_delay_reload_q;
      len_sh = `FTAR_SH_ONE;
      case (state_q)
         S_TRAN: len_cnt = transition_time_reload_q;
         S_PULSE:
         begin
            if (kind_q == `FTAR_OP_PROG)
            begin
               len_cnt = program_pulse_reload_q;
               len_sh = `FTAR_SH_PROG;
            end
            else if (kind_q == `FTAR_OP_PERASE)
            begin
               len_cnt = page_erase_pulse_reload_q;
               len_sh = `FTAR_SH_ERASE;
            end
            else
            begin
               len_cnt = module_erase_pulse_reload_q;
               len_sh = `FTAR_SH_ERASE;
            end
         end
         S_END:
         begin
            if (kind_q[1]) // Codes 2 and 3 both module erase
            begin
               len_cnt = module_erase_end_reload_q;
               len_sh = `FTAR_SH_MEND;
            end
            else
               len_cnt = end_delay_reload_q;
         end
         S_RCV: len_cnt = recovery_delay_reload_q;
         default: len_cnt = start_delay_reload_q;
      endcase
      len = ({{(DW-8){1'b0}}, len_cnt} + {{(DW-1){1'b0}}, 1'b1}) << len_sh;
   end

   ftar_delay #(
      .W(DW)
   ) ftar_delay_i (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_load(load_q),
      .i_len(len),
      .i_tick(tick_q),
      .o_done(dly_done)
   );

   // ************************************
   // Operation sequencer
   // ************************************
   // Next phase on each delay end
   always @*
   begin
      state_d = state_q;
      case (state_q)
         S_IDLE:
            if (i_op_start && init_done_q)
               state_d = S_START;
         S_START:
            if (dly_done)
               state_d = S_TRAN;
         S_TRAN:
            if (dly_done)
               state_d = S_PULSE;
         S_PULSE:
            if (dly_done)
               state_d = S_END;
         S_END:
            if (dly_done)
               state_d = S_RCV;
         S_RCV:
            if (dly_done)
               state_d = S_IDLE;
         default: state_d = S_IDLE;
      endcase
   end

   // State, delay load and array strobes
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         state_q <= S_IDLE;
         kind_q <= `FTAR_OP_PROG;
         load_q <= 1'b0;
         o_flash_busy <= 1'b0;
         o_prog_pulse <= 1'b0;
         o_erase_pulse <= 1'b0;
         o_op_done <= 1'b0;
         o_init_done <= 1'b0;
         o_prot_word <= 16'h0000;
         o_code_area_start <= 16'h0000;
      end
      else
      begin
         state_q <= state_d;
         load_q <= (state_d != state_q) && (state_d != S_IDLE);
         if (state_q == S_IDLE && state_d == S_START)
            kind_q <= i_op_kind;
         o_flash_busy <= (state_d != S_IDLE);
         o_prog_pulse <= (state_d == S_PULSE) && (kind_q == `FTAR_OP_PROG);
         o_erase_pulse <= (state_d == S_PULSE) && (kind_q != `FTAR_OP_PROG);
         o_op_done <= (state_q == S_RCV) && (state_d == S_IDLE);
         o_init_done <= init_done_q;
         if (init_done_q)
         begin
            o_prot_word <= protection_word_copy_q;
            o_code_area_start <= code_area_start_q;
         end
      end
   end

endmodule // ftar_top

// ---- tb/ftar_array_model.sv ----
// ********
// Flash array side
// ********
module ftar_array_model #(
   parameter logic [15:0] FUNC = 16'h1234, // Arbitrary value
   parameter logic [15:0] PROT = 16'ha5c9, // Arbitrary value
   parameter logic [15:0] CAS = 16'h8765 // Arbitrary value
) (
   input wire logic i_prog_pulse, // Program pulse
   input wire logic i_erase_pulse, // Erase pulse
   input wire logic i_hold_busy, // Keep array busy
   output logic o_array_busy, // Array busy level
   output logic [15:0] o_func_word, // Info block 0 word
   output logic [15:0] o_prot_word, // Info block 1 word
   output logic [15:0] o_cas_addr // Code area straps
);
   timeunit 1ns;
   timeprecision 1ps;
   // Array stays busy while pulsed or held
   assign o_array_busy = i_hold_busy | i_prog_pulse | i_erase_pulse;
   // Info block words stand still
   assign o_func_word = FUNC;
   assign o_prot_word = PROT;
   assign o_cas_addr = CAS;
endmodule // ftar_array_model

// ---- tb/ftar_top_properties.sv ----
// ********
// Port checks
// ********
module ftar_top_properties #(
   parameter DW = 21
) (
   input wire logic i_clk, // Clock
   input wire logic i_nrst, // Reset
   input wire logic [3:0] i_reg_idx, // Index
   input wire logic i_reg_wr, // Write
   input wire logic i_reg_rd, // Read
   input wire logic [7:0] i_reg_wdata, // Write data
   input wire logic [15:0] o_reg_rdata, // Read data
   input wire logic i_op_start, // Start
   input wire logic [1:0] i_op_kind, // Kind
   input wire logic i_array_busy, // Array busy
   input wire logic [15:0] i_func_word, // Function word
   input wire logic [15:0] i_prot_word, // Protection word
   input wire logic [15:0] i_cas_addr, // Straps
   input wire logic o_flash_busy, // Busy
   input wire logic o_prog_pulse, // Program pulse
   input wire logic o_erase_pulse, // Erase pulse
   input wire logic o_op_done, // Done
   input wire logic o_init_done, // Init done
   input wire logic [15:0] o_prot_word, // Protection
   input wire logic [15:0] o_code_area_start // Start
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);
   AST_PULSE_EXCL: assert property (!(o_prog_pulse && o_erase_pulse))
      else $error("both pulses high");
   AST_PULSE_BUSY: assert property ((o_prog_pulse || o_erase_pulse) |-> o_flash_busy)
      else $error("pulse without busy");
   AST_START_BUSY: assert property (i_op_start && !o_flash_busy && o_init_done |=> o_flash_busy)
      else $error("start not taken");
   AST_DONE_IDLE: assert property (o_op_done |-> !o_flash_busy && !o_prog_pulse)
      else $error("done while busy");
   AST_DONE_ONE: assert property (o_op_done |=> !o_op_done)
      else $error("done longer than one cycle");
   AST_PROG_MIN: assert property ($rose(o_prog_pulse) |-> o_prog_pulse [*8])
      else $error("program pulse too short");
   AST_ERASE_MIN: assert property ($rose(o_erase_pulse) |-> o_erase_pulse [*8])
      else $error("erase pulse too short");
   AST_CAS_FIELD: assert property (o_init_done |-> o_code_area_start[14:11] == o_prot_word[3:0])
      else $error("boot area field wrong");
   AST_PROT_STABLE: assert property (o_init_done && $past(o_init_done) |-> $stable(o_prot_word))
      else $error("protection word changed");
   AST_RDATA_HOLD: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
      else $error("read data changed without read");
endmodule // ftar_top_properties

bind ftar_top ftar_top_properties #(.DW(DW)) ftar_top_properties_i (.i_clk, .i_nrst,
   .i_reg_idx, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .i_op_start, .i_op_kind,
   .i_array_busy, .i_func_word, .i_prot_word, .i_cas_addr, .o_flash_busy, .o_prog_pulse,
   .o_erase_pulse, .o_op_done, .o_init_done, .o_prot_word, .o_code_area_start);

// ---- tb/ftar_top_tb_top.sv ----
// ********
// Register and sequence tests
// ********
module ftar_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] FUNC = 16'h1234; // Arbitrary value
   localparam logic [15:0] PROT = 16'ha5c9; // Arbitrary value
   localparam logic [15:0] CAS = 16'h8765; // Arbitrary value
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic [3:0] i_reg_idx = 4'h0;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic [7:0] i_reg_wdata = 8'h00;
   logic i_op_start = 1'b0;
   logic [1:0] i_op_kind = 2'h0;
   logic hold_busy = 1'b0;
   wire logic arr_busy, busy, prog, erase, done, init;
   wire logic [15:0] func_w, prot_w, cas_w, rdata, prot_o, cas_o;
   int mismatches = 0;
   int checked = 0;
   int cycles = 0;
   int pw, bw, b0;
   logic [7:0] dflt [9] = '{8'h18, 8'h30, 8'h16, 8'h04, 8'hea, 8'h18, 8'h3c, 8'h04, 8'h04};
   logic [15:0] ar [3] = '{FUNC, PROT, {CAS[15], PROT[3:0], CAS[10:0]}};

   ftar_top ftar_top_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_reg_idx(i_reg_idx),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(rdata),
      .i_op_start(i_op_start), .i_op_kind(i_op_kind), .i_array_busy(arr_busy),
      .i_func_word(func_w), .i_prot_word(prot_w), .i_cas_addr(cas_w), .o_flash_busy(busy),
      .o_prog_pulse(prog), .o_erase_pulse(erase), .o_op_done(done), .o_init_done(init),
      .o_prot_word(prot_o), .o_code_area_start(cas_o));
   ftar_array_model #(.FUNC(FUNC), .PROT(PROT), .CAS(CAS)) ftar_array_model_i (
      .i_prog_pulse(prog), .i_erase_pulse(erase), .i_hold_busy(hold_busy),
      .o_array_busy(arr_busy), .o_func_word(func_w), .o_prot_word(prot_w), .o_cas_addr(cas_w));

   // Clock and hang guard
   always #12.5 i_clk = ~i_clk;
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         mismatches++;
         close_out();
      end
   end

   task close_out;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   function logic [15:0] inr(input int v, input int lo, input int hi);
      return (v >= lo && v <= hi) ? 16'h0001 : 16'h0000;
   endfunction

   task tick;
      @(posedge i_clk);
      #2;
   endtask

   task wr(input logic [3:0] idx, input logic [7:0] d);
      i_reg_idx = idx;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      tick();
      i_reg_wr = 1'b0;
      tick();
   endtask

   task rdc(input logic [3:0] idx, input logic [15:0] exp);
      i_reg_idx = idx;
      i_reg_rd = 1'b1;
      tick();
      check(rdata, exp);
      i_reg_rd = 1'b0;
      tick();
   endtask

   task reset_dut;
      i_nrst = 1'b0;
      repeat (2) tick();
      i_nrst = 1'b1;
      for (int n = 0; n < 20 && init !== 1'b1; n++) tick();
      check(init, 1'b1);
   endtask

   // Start, then count pulse and busy cycles until done
   task op(input logic [1:0] k, input logic [3:0] idx, input logic [7:0] d);
      pw = 0;
      bw = 0;
      i_op_kind = k;
      i_op_start = 1'b1;
      tick();
      i_op_start = 1'b0;
      check(busy, 1'b1);
      if (idx != 4'h0) wr(idx, d);
      for (int n = 0; n < 20000 && done !== 1'b1; n++)
      begin
         if (prog | erase) pw++;
         bw++;
         tick();
      end
      check(done, 1'b1);
      check(busy, 1'b0);
      tick();
   endtask

   // Main sequence
   initial
   begin
      reset_dut();
      for (int i = 0; i < 9; i++) rdc(i[3:0], {8'h00, dflt[i]});
      for (int i = 0; i < 6; i++) rdc(4'h9 + i[3:0], ar[i % 3]);
      check(prot_o, PROT);
      check(cas_o, ar[2]);
      wr(4'h9, 8'hff);
      wr(4'hb, 8'h00);
      rdc(4'h9, ar[0]);
      rdc(4'hb, ar[2]);
      rdc(4'hf, 16'h0000);
      for (int i = 0; i < 9; i++) wr(i[3:0], 8'h00);
      wr(4'h2, 8'h01);
      rdc(4'h2, 16'h0001);
      op(2'h0, 4'h0, 8'h00);
      check(inr(pw, 16, 18), 16'h0001);
      check(inr(bw, 20, 32), 16'h0001);
      b0 = bw;
      wr(4'h1, 8'h03);
      wr(4'h5, 8'h02);
      wr(4'h7, 8'h05);
      op(2'h0, 4'h0, 8'h00);
      check(16'(bw - b0), 16'd10);
      op(2'h1, 4'h0, 8'h00);
      check(inr(pw, 4096, 4098), 16'h0001);
      op(2'h2, 4'h0, 8'h00);
      check(inr(pw, 4096, 4098), 16'h0001);
      b0 = bw;
      wr(4'h6, 8'h01);
      op(2'h2, 4'h0, 8'h00);
      check(16'(bw - b0), 16'd8);
      op(2'h3, 4'h0, 8'h00);
      check(16'(bw - b0), 16'd8);
      wr(4'h8, 8'h01);
      op(2'h0, 4'h1, 8'h77);
      check(inr(pw, 32, 35), 16'h0001);
      rdc(4'h1, 16'h0003);
      hold_busy = 1'b1;
      reset_dut();
      hold_busy = 1'b0;
      rdc(4'h1, 16'h0003);
      rdc(4'h8, 16'h0001);
      close_out();
   end
endmodule // ftar_top_tb_top
